// File: csp_pkg.sv
// shared constants and types for the serial register port
package csp_pkg;

  // core clock and idle timeout
  localparam int CLK_PERIOD_NS = 25;
  localparam int IDLE_TIMEOUT_NS = 1500000;
  localparam int IDLE_TIMEOUT_CYC =
    (IDLE_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // frame bit positions, counted from zero
  localparam logic [4:0] POS_START2 = 5'h01;
  localparam logic [4:0] POS_CMD_LAST = 5'h07;
  localparam logic [4:0] POS_DATA_FIRST = 5'h08;
  localparam logic [4:0] POS_CRC_FIRST = 5'h14;
  localparam logic [4:0] POS_LAST = 5'h17;
  localparam logic [1:0] START_CODE = 2'h1;

  // register addresses with side effects
  localparam logic [3:0] ADR_IFR = 4'h6;
  localparam logic [3:0] ADR_TRANSCEIVER_STATUS_REGISTER = 4'h7;
  localparam logic [3:0] ADR_SYS = 4'hF;

  // register fields
  localparam int IFR_PROTO_BIT = 11;
  localparam int IFR_CRC_BIT = 10;
  localparam int IFR_RESUME_BIT = 9;
  localparam logic [11:0] IFR_EVT_MASK = 12'hE00;
  localparam int SYS_CRCOFF_BIT = 7;
  localparam logic [11:0] REG_RESET = 12'h000;

  typedef enum logic [1:0] {
    CMD_READ = 2'b00,
    CMD_WRITE = 2'b01,
    CMD_CLEAR = 2'b10,
    CMD_MUTE = 2'b11
  } csp_cmd_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SHIFT = 2'b01,
    ST_DISCARD = 2'b10,
    ST_MUTE = 2'b11
  } csp_state_t;

  // implemented bits of each register
  function automatic logic [11:0] regMask(input logic [3:0] a);
    unique case (a)
      4'h6, 4'h8, 4'h9, 4'hA, 4'hE: regMask = 12'hFFF;
      4'h7: regMask = 12'h1FF;
      4'hB, 4'hC, 4'hD: regMask = 12'h000;
      default: regMask = 12'h0FF;
    endcase
  endfunction : regMask

  // one step of division by x^4 + 1
  function automatic logic [3:0] crc4Step(input logic [3:0] c,
                                          input logic b);
    crc4Step = {c[2:0], c[3] ^ b};
  endfunction : crc4Step

endpackage : csp_pkg

// File: csp_link_if.sv
// serial link events passed from the sampler to the frame logic
`timescale 1ns/100ps
interface csp_link_if;
  logic sclkRise;
  logic sclkFall;
  logic sinBit;
  modport src (output sclkRise, output sclkFall, output sinBit);
  modport dst (input sclkRise, input sclkFall, input sinBit);
endinterface : csp_link_if

// File: csp_link_sync.sv
// synchronises the serial clock and data and finds clock edges
`timescale 1ns/100ps
module csp_link_sync (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // pins
  input wire logic serialClk,
  input wire logic serialIn,
  // events
  csp_link_if.src link
);

  logic sclkS1_q;
  logic sclkS2_q;
  logic sclkPrev_q;
  logic sinS1_q;
  logic sinS2_q;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      sclkS1_q <= 1'b0;
      sclkS2_q <= 1'b0;
      sclkPrev_q <= 1'b0;
      sinS1_q <= 1'b0;
      sinS2_q <= 1'b0;
    end else begin
      sclkS1_q <= serialClk;
      sclkS2_q <= sclkS1_q;
      sclkPrev_q <= sclkS2_q;
      sinS1_q <= serialIn;
      sinS2_q <= sinS1_q;
    end
  end

  assign link.sclkRise = sclkS2_q & ~sclkPrev_q;
  assign link.sclkFall = ~sclkS2_q & sclkPrev_q;
  assign link.sinBit = sinS2_q;

endmodule : csp_link_sync

// File: csp_crc4.sv
// four bit check code accumulator over a serial bit stream
`timescale 1ns/100ps
module csp_crc4 (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // stream
  input wire logic shift,
  input wire logic first,
  input wire logic bitIn,
  // result
  output logic [3:0] crc
);

  logic [3:0] crc_q;
  wire [3:0] base = first ? 4'h0 : crc_q;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      crc_q <= 4'h0;
    end else if (shift) begin
      crc_q <= csp_pkg::crc4Step(base, bitIn);
    end
  end

  assign crc = crc_q;

endmodule : csp_crc4

// File: csp_serial_port.sv
// serial register port with echo, check codes and output muting
`timescale 1ns/100ps
module csp_serial_port #(
  parameter int IDLE_TIMEOUT = csp_pkg::IDLE_TIMEOUT_CYC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // serial link pins
  input wire logic serialClk,
  input wire logic serialIn,
  output logic serialOut,
  output logic serialOutEn_n,
  output logic interruptRequest_n,
  // register port
  input wire logic [3:0] regAddr,
  input wire logic [11:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [11:0] regRdData
);

  localparam logic [19:0] TO_LAST = 20'(IDLE_TIMEOUT - 1);

  csp_link_if link ();

  csp_link_sync uSync (
    .core_clk(core_clk),
    .rst(rst),
    .serialClk(serialClk),
    .serialIn(serialIn),
    .link(link)
  );

  // frame state
  csp_pkg::csp_state_t state_q;
  csp_pkg::csp_state_t state_d;
  logic [4:0] pos_q;
  logic [4:0] pos_d;
  logic [19:0] idleCnt_q;

  // input shifters
  logic [7:0] cmdSh_q;
  logic [11:0] dataSh_q;
  logic [3:0] crcSh_q;
  logic lastIn_q;
  logic [3:0] addr_q;
  csp_pkg::csp_cmd_t cmd_q;

  // output shifter
  logic [11:0] outSh_q;

  // pin and port flops
  logic serialOut_q;
  logic outEnN_q;
  logic irqN_q;
  logic [11:0] rdData_q;

  // register file
  logic crcOff_q;
  logic [11:0] regs_q [16];
  logic [11:0] regD [16];
  logic [11:0] regView [16];

  // check codes
  logic [3:0] inCrc;
  logic [3:0] outCrc;

  // link events
  wire rise = link.sclkRise;
  wire fall = link.sclkFall;
  wire inBit = link.sinBit;

  // input side decode
  wire listening = (state_q == csp_pkg::ST_IDLE) ||
                   (state_q == csp_pkg::ST_SHIFT);
  wire takeBit = rise && listening;
  wire atStart2 = takeBit && (pos_q == csp_pkg::POS_START2);
  wire [1:0] startCode = {cmdSh_q[0], inBit};
  wire badStart = atStart2 &&
                  (startCode != csp_pkg::START_CODE);
  wire atCmdLast = takeBit && (pos_q == csp_pkg::POS_CMD_LAST);
  wire [3:0] newAddr = cmdSh_q[4:1];
  wire [1:0] newCmd = {cmdSh_q[0], inBit};
  wire inData = (pos_q >= csp_pkg::POS_DATA_FIRST) &&
                (pos_q < csp_pkg::POS_CRC_FIRST);
  wire inCrcField = pos_q >= csp_pkg::POS_CRC_FIRST;
  wire atEnd = takeBit && (pos_q == csp_pkg::POS_LAST);

  // end of frame actions
  wire [3:0] crcRx = {crcSh_q[2:0], inBit};
  wire crcOk = crcRx == inCrc;
  wire [11:0] rxWord = {dataSh_q[3:0], dataSh_q[11:4]};
  wire isWrite = atEnd && (cmd_q == csp_pkg::CMD_WRITE);
  wire crcFail = atEnd && !crcOk && !crcOff_q;
  wire wrAllowed = isWrite && (crcOk || crcOff_q);
  wire sysToggle = isWrite && crcOk &&
                   (addr_q == csp_pkg::ADR_SYS);
  wire serialWr = wrAllowed &&
                  (addr_q != csp_pkg::ADR_TRANSCEIVER_STATUS_REGISTER) &&
                  (addr_q != csp_pkg::ADR_SYS);
  wire clrRead = atEnd && (cmd_q == csp_pkg::CMD_CLEAR) &&
                 (addr_q == csp_pkg::ADR_IFR);

  // idle timeout
  wire timedOut = idleCnt_q == TO_LAST;
  wire abortFrame = timedOut &&
                    ((state_q == csp_pkg::ST_SHIFT) ||
                     (state_q == csp_pkg::ST_DISCARD));
  wire resume = timedOut && (state_q == csp_pkg::ST_MUTE);

  // output side decode
  wire talking = fall && (state_q == csp_pkg::ST_SHIFT);
  wire echoPhase = pos_q < csp_pkg::POS_DATA_FIRST;
  wire crcLoad = pos_q == csp_pkg::POS_CRC_FIRST;
  wire crcPhase = pos_q >= csp_pkg::POS_CRC_FIRST;
  wire outBit = echoPhase ? lastIn_q :
                crcLoad ? outCrc[3] :
                outSh_q[11];
  wire outCrcShift = talking && !crcPhase;
  wire outCrcFirst = pos_q == 5'h01;
  wire inCrcShift = takeBit && !inCrcField;
  wire inCrcFirst = pos_q == 5'h00;

  // hardware events into the flag register
  wire [11:0] events =
    (12'(badStart) << csp_pkg::IFR_PROTO_BIT) |
    (12'(crcFail) << csp_pkg::IFR_CRC_BIT) |
    (12'(resume) << csp_pkg::IFR_RESUME_BIT);

  // check code over received bits
  csp_crc4 uInCrc (
    .core_clk(core_clk),
    .rst(rst),
    .shift(inCrcShift),
    .first(inCrcFirst),
    .bitIn(inBit),
    .crc(inCrc)
  );

  // check code over sent bits
  csp_crc4 uOutCrc (
    .core_clk(core_clk),
    .rst(rst),
    .shift(outCrcShift),
    .first(outCrcFirst),
    .bitIn(outBit),
    .crc(outCrc)
  );

  // frame sequencing
  always_comb begin
    state_d = state_q;
    pos_d = pos_q;
    if (resume) begin
      state_d = csp_pkg::ST_IDLE;
      pos_d = 5'h00;
    end else if (abortFrame) begin
      state_d = csp_pkg::ST_IDLE;
      pos_d = 5'h00;
    end else if (badStart) begin
      state_d = csp_pkg::ST_DISCARD;
      pos_d = 5'h00;
    end else if (atEnd) begin
      pos_d = 5'h00;
      if (cmd_q == csp_pkg::CMD_MUTE) begin
        state_d = csp_pkg::ST_MUTE;
      end else begin
        state_d = csp_pkg::ST_IDLE;
      end
    end else if (takeBit) begin
      state_d = csp_pkg::ST_SHIFT;
      pos_d = pos_q + 5'h01;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q <= csp_pkg::ST_IDLE;
      pos_q <= 5'h00;
    end else begin
      state_q <= state_d;
      pos_q <= pos_d;
    end
  end

  // time since the last serial clock edge
  always_ff @(posedge core_clk) begin
    if (rst || rise || fall) begin
      idleCnt_q <= 20'h00000;
    end else if (!timedOut) begin
      idleCnt_q <= idleCnt_q + 20'h00001;
    end
  end

  // input shifters
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cmdSh_q <= 8'h00;
      dataSh_q <= 12'h000;
      crcSh_q <= 4'h0;
      lastIn_q <= 1'b0;
    end else if (takeBit) begin
      lastIn_q <= inBit;
      if (inCrcFirst) begin
        cmdSh_q <= {7'h00, inBit};
        dataSh_q <= 12'h000;
        crcSh_q <= 4'h0;
      end else if (echoPhase) begin
        cmdSh_q <= {cmdSh_q[6:0], inBit};
      end else if (inData) begin
        dataSh_q <= {dataSh_q[10:0], inBit};
      end else begin
        crcSh_q <= {crcSh_q[2:0], inBit};
      end
    end
  end

  // address and command of the running frame
  always_ff @(posedge core_clk) begin
    if (rst) begin
      addr_q <= 4'h0;
      cmd_q <= csp_pkg::CMD_READ;
    end else if (atCmdLast) begin
      addr_q <= newAddr;
      cmd_q <= csp_pkg::csp_cmd_t'(newCmd);
    end
  end

  // output shifter, loaded with the addressed register
  always_ff @(posedge core_clk) begin
    if (rst) begin
      outSh_q <= 12'h000;
    end else if (atCmdLast) begin
      outSh_q <= {regView[newAddr][7:0],
                  regView[newAddr][11:8]};
    end else if (talking && !echoPhase) begin
      if (crcLoad) begin
        outSh_q <= {outCrc[2:0], 9'h000};
      end else begin
        outSh_q <= {outSh_q[10:0], 1'b0};
      end
    end
  end

  // serial output pin, enable low while driving
  always_ff @(posedge core_clk) begin
    if (rst) begin
      serialOut_q <= 1'b0;
      outEnN_q <= 1'b0;
    end else begin
      outEnN_q <= state_d == csp_pkg::ST_MUTE;
      if (talking) begin
        serialOut_q <= outBit;
      end
    end
  end

  // register read view with undefined bits forced low
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      regView[i] = regs_q[i] & csp_pkg::regMask(4'(i));
    end
    regView[csp_pkg::ADR_SYS][csp_pkg::SYS_CRCOFF_BIT] = crcOff_q;
  end

  // register next values, serial write wins over port write
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      regD[i] = regs_q[i];
      if (regWr && (regAddr == 4'(i))) begin
        regD[i] = regWrData & csp_pkg::regMask(4'(i));
      end
      if (serialWr && (addr_q == 4'(i))) begin
        regD[i] = rxWord & csp_pkg::regMask(4'(i));
      end
    end
    if (clrRead) begin
      regD[csp_pkg::ADR_IFR] = 12'h000;
    end
    regD[csp_pkg::ADR_IFR] = regD[csp_pkg::ADR_IFR] | events;
  end

  always_ff @(posedge core_clk) begin
    for (int i = 0; i < 16; i++) begin
      if (rst) begin
        regs_q[i] <= csp_pkg::REG_RESET;
      end else begin
        regs_q[i] <= regD[i];
      end
    end
  end

  // check code verification toggle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      crcOff_q <= 1'b0;
    end else if (sysToggle) begin
      crcOff_q <= ~crcOff_q;
    end
  end

  // interrupt line low while any event flag is set
  always_ff @(posedge core_clk) begin
    if (rst) begin
      irqN_q <= 1'b1;
    end else begin
      irqN_q <= ~|(regs_q[csp_pkg::ADR_IFR] &
                   csp_pkg::IFR_EVT_MASK);
    end
  end

  // register port read data
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdData_q <= 12'h000;
    end else if (regRd) begin
      rdData_q <= regView[regAddr];
    end
  end

  assign serialOut = serialOut_q;
  assign serialOutEn_n = outEnN_q;
  assign interruptRequest_n = irqN_q;
  assign regRdData = rdData_q;

endmodule : csp_serial_port

// File: csp_serial_port_chk.sv
// pin level assertions for the serial register port
`timescale 1ns/100ps
module csp_serial_port_chk #(
  parameter int IDLE_TIMEOUT = 200
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // serial pins
  input wire logic serialClk,
  input wire logic serialIn,
  input wire logic serialOut,
  input wire logic serialOutEn_n,
  input wire logic interruptRequest_n,
  // register port
  input wire logic [3:0] regAddr,
  input wire logic [11:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [11:0] regRdData
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic clkQ;
  logic [15:0] idleCnt;
  // cycles since the serial clock last moved
  always_ff @(posedge core_clk) begin
    clkQ <= serialClk;
    if (rst || clkQ != serialClk) idleCnt <= 16'h0000;
    else if (idleCnt != 16'hFFFF) idleCnt <= idleCnt + 16'h0001;
  end
  a_out_on_fall: assert property (
    $changed(serialOut) |-> !$past(serialClk, 2)) else $error("out moved");
  a_resume_time: assert property ($fell(serialOutEn_n) |->
    idleCnt >= IDLE_TIMEOUT - 8 && idleCnt <= IDLE_TIMEOUT + 8)
    else $error("resume time");
  a_resume_irq: assert property ($fell(serialOutEn_n) |->
    ##[0:3] !interruptRequest_n) else $error("no resume irq");
  a_nav_zero: assert property (
    regRd && regAddr inside {4'hB, 4'hC, 4'hD} |=> regRdData == 12'h000)
    else $error("nav not zero");
  a_byte_regs: assert property (
    regRd && regAddr < 4'h6 |=> regRdData[11:8] == 4'h0)
    else $error("byte reg high");
  a_status_bits: assert property (
    regRd && regAddr == 4'h7 |=> regRdData[11:9] == 3'h0)
    else $error("status high");
  a_write_back: assert property (
    regWr && regAddr == 4'h8 ##1 regRd && regAddr == 4'h8
    |=> regRdData == $past(regWrData, 2)) else $error("write back");
  a_irq_level: assert property (regRd && regAddr == 4'h6 |=>
    interruptRequest_n == !(|regRdData[11:9])) else $error("irq level");
  c_mute: cover property ($rose(serialOutEn_n));
  c_irq: cover property ($fell(interruptRequest_n));
  c_resume: cover property ($fell(serialOutEn_n));
endmodule : csp_serial_port_chk
bind csp_serial_port csp_serial_port_chk #(.IDLE_TIMEOUT(IDLE_TIMEOUT)) u_chk (
  .core_clk(core_clk), .rst(rst), .serialClk(serialClk),
  .serialIn(serialIn), .serialOut(serialOut), .serialOutEn_n(serialOutEn_n),
  .interruptRequest_n(interruptRequest_n), .regAddr(regAddr),
  .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
  .regRdData(regRdData));

// File: csp_host_model.sv
// host side serial master that sends frames and captures the reply
`timescale 1ns/100ps
module csp_host_model (
  // clock
  core_clk,
  // serial pins
  serialClk,
  serialIn,
  serialOut,
  serialOutEn_n
);
  input wire logic core_clk;
  output logic serialClk;
  output logic serialIn;
  input wire logic serialOut;
  input wire logic serialOutEn_n;
  logic rxLine;
  // muted output floats to the pull-up
  assign rxLine = serialOutEn_n ? 1'b1 : serialOut;
  initial begin
    serialClk = 1'b0;
    serialIn = 1'b0;
  end
  // remainder of division by x^4 + 1, msb first
  function automatic logic [3:0] crc(input logic [19:0] v, input int n);
    crc = 4'h0;
    for (int i = n - 1; i >= 0; i--) crc = {crc[2:0], crc[3] ^ v[i]};
  endfunction : crc
  function automatic logic [23:0] mk(input logic [3:0] a,
      input logic [1:0] c, input logic [11:0] v, input logic bad);
    logic [19:0] h;
    h = {2'h1, a, c, v[7:0], v[11:8]};
    mk = {h, crc(h, 20) ^ {3'h0, bad}};
  endfunction : mk
  // sends the top n bits, one reply bit per slot
  task automatic frame(input logic [23:0] f, input int n,
      output logic [23:0] r);
    r = 24'h000000;
    for (int i = 0; i < n; i++) begin
      serialIn <= f[23 - i];
      repeat (4) @(posedge core_clk);
      serialClk <= 1'b1;
      repeat (3) @(posedge core_clk);
      @(negedge core_clk);
      r[23 - i] = rxLine;
      @(posedge core_clk);
      serialClk <= 1'b0;
    end
    serialIn <= ~f[24 - n];
  endtask : frame
endmodule : csp_host_model

// File: tb.sv
// testbench for the serial register port
`timescale 1ns/100ps
module tb;
  localparam int IDLE = 200;
  logic core_clk, rst, serialClk, serialIn, serialOut, serialOutEn_n;
  logic interruptRequest_n, regWr, regRd;
  logic [3:0] regAddr;
  logic [11:0] regWrData, regRdData;
  logic [23:0] f, r;
  int n_fail = 0;
  int compares = 0;
  csp_serial_port #(.IDLE_TIMEOUT(IDLE)) u_csp_serial_port (
    .core_clk(core_clk), .rst(rst), .serialClk(serialClk),
    .serialIn(serialIn), .serialOut(serialOut),
    .serialOutEn_n(serialOutEn_n), .interruptRequest_n(interruptRequest_n),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData));
  csp_host_model u_csp_host_model (.core_clk(core_clk),
    .serialClk(serialClk), .serialIn(serialIn), .serialOut(serialOut),
    .serialOutEn_n(serialOutEn_n));
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    compares++;
    if (g !== e) begin
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
      n_fail++;
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [11:0] v);
    regAddr <= a;
    regWrData <= v;
    regWr <= 1'b1;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [11:0] e);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge core_clk);
    regRd <= 1'b0;
    @(negedge core_clk);
    chk(regRdData, e);
    @(posedge core_clk);
  endtask : rd
  task automatic ser(input logic [3:0] a, input logic [1:0] c,
      input logic [11:0] v, input logic b, input logic [11:0] o);
    logic [18:0] e;
    f = u_csp_host_model.mk(a, c, v, b);
    u_csp_host_model.frame(f, 24, r);
    e = {f[23:17], o[7:0], o[11:8]};
    chk(r[22:0], {e, u_csp_host_model.crc({1'b0, e}, 19)});
    repeat (4) @(posedge core_clk);
  endtask : ser
  task automatic t_port();
    wr(4'h0, 12'hFFF);
    rd(4'h0, 12'h0FF);
    wr(4'h8, 12'hABC);
    rd(4'h8, 12'hABC);
    wr(4'hB, 12'hFFF);
    rd(4'hB, 12'h000);
    $display("t_port done");
  endtask : t_port
  task automatic t_ser();
    wr(4'h9, 12'h123);
    rd(4'h9, 12'h123);
    ser(4'h9, 2'h1, 12'hA5C, 1'b0, 12'h123);
    rd(4'h9, 12'hA5C);
    ser(4'h1, 2'h1, 12'h0F3, 1'b0, 12'h000);
    ser(4'h1, 2'h0, 12'hFFF, 1'b0, 12'h0F3);
    wr(4'h7, 12'h0AB);
    ser(4'h7, 2'h1, 12'h155, 1'b0, 12'h0AB);
    rd(4'h7, 12'h0AB);
    $display("t_ser done");
  endtask : t_ser
  task automatic t_crc();
    ser(4'h9, 2'h1, 12'h111, 1'b1, 12'hA5C);
    rd(4'h9, 12'hA5C);
    chk(interruptRequest_n, 1'b0);
    rd(4'h6, 12'h400);
    ser(4'h9, 2'h2, 12'h000, 1'b0, 12'hA5C);
    rd(4'h9, 12'hA5C);
    ser(4'h6, 2'h2, 12'h000, 1'b0, 12'h400);
    rd(4'h6, 12'h000);
    ser(4'hF, 2'h1, 12'h000, 1'b0, 12'h000);
    rd(4'hF, 12'h080);
    ser(4'h9, 2'h1, 12'h222, 1'b1, 12'hA5C);
    rd(4'h9, 12'h222);
    ser(4'hF, 2'h1, 12'h000, 1'b0, 12'h080);
    rd(4'hF, 12'h000);
    $display("t_crc done");
  endtask : t_crc
  task automatic t_proto();
    f = u_csp_host_model.mk(4'h9, 2'h1, 12'h333, 1'b0);
    f[22] = 1'b0;
    u_csp_host_model.frame(f, 24, r);
    repeat (4) @(posedge core_clk);
    rd(4'h9, 12'h222);
    rd(4'h6, 12'h800);
    chk(interruptRequest_n, 1'b0);
    repeat (IDLE + 20) @(posedge core_clk);
    ser(4'h6, 2'h2, 12'h000, 1'b0, 12'h800);
    f = u_csp_host_model.mk(4'h9, 2'h1, 12'h333, 1'b0);
    u_csp_host_model.frame(f, 10, r);
    repeat (IDLE + 20) @(posedge core_clk);
    ser(4'h9, 2'h0, 12'h000, 1'b0, 12'h222);
    $display("t_proto done");
  endtask : t_proto
  task automatic t_mute();
    f = u_csp_host_model.mk(4'h0, 2'h3, 12'h000, 1'b0);
    u_csp_host_model.frame(f, 24, r);
    repeat (4) @(posedge core_clk);
    chk(serialOutEn_n, 1'b1);
    repeat (IDLE + 20) @(posedge core_clk);
    chk(serialOutEn_n, 1'b0);
    rd(4'h6, 12'h200);
    wr(4'h6, 12'h000);
    rd(4'h6, 12'h000);
    chk(interruptRequest_n, 1'b1);
    $display("t_mute done");
  endtask : t_mute
  task automatic wrap_up();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : wrap_up
  initial begin
    rst = 1'b1;
    regAddr = 4'h0;
    regWrData = 12'h000;
    regWr = 1'b0;
    regRd = 1'b0;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    repeat (4) @(posedge core_clk);
    rd(4'h9, 12'h000);
    chk(interruptRequest_n, 1'b1);
    t_port();
    t_ser();
    t_crc();
    t_proto();
    t_mute();
    wrap_up();
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    n_fail++;
    wrap_up();
  end
endmodule : tb
